// ===== core/ccfe_pkg.sv
package ccfe_pkg;

  localparam logic [7:0] REG_FLAGS   = 8'h00;
  localparam logic [7:0] REG_ACC     = 8'h04;
  localparam logic [7:0] REG_INDEX   = 8'h08;
  localparam logic [7:0] REG_PC      = 8'h0c;
  localparam logic [7:0] REG_ALU_CMD = 8'h10;
  localparam logic [7:0] REG_EA_CMD  = 8'h14;
  localparam logic [7:0] REG_EA      = 8'h18;
  localparam logic [7:0] REG_STATUS  = 8'h1c;

  localparam int ALU_OP_LSB  = 0;
  localparam int ALU_OPN_LSB = 8;
  localparam int ALU_BIT_LSB = 16;
  localparam int EA_MODE_LSB = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_EXT_BIT  = 1;
  localparam int ST_TMR_BIT  = 2;
  localparam int ST_LEN_LSB  = 4;

  localparam logic [2:0]  FLAG_PAD   = 3'h7;
  localparam logic [7:0]  ACC_RST    = 8'h00;
  localparam logic [7:0]  INDEX_RST  = 8'h00;
  localparam logic [15:0] PC_RST     = 16'h0000;
  localparam logic [15:0] EA_RST     = 16'h0000;

  typedef enum logic [3:0] {
    CCFE_OP_ADD, CCFE_OP_ADC, CCFE_OP_SUB, CCFE_OP_SBC, CCFE_OP_CMP,
    CCFE_OP_AND, CCFE_OP_ORA, CCFE_OP_EOR, CCFE_OP_LDA, CCFE_OP_LSL,
    CCFE_OP_LSR, CCFE_OP_ASR, CCFE_OP_ROL, CCFE_OP_ROR, CCFE_OP_BTST
  } ccfe_op_e;

  typedef enum logic [2:0] {
    CCFE_AM_IMM, CCFE_AM_DIR, CCFE_AM_EXT, CCFE_AM_IX0, CCFE_AM_IX1, CCFE_AM_IX2
  } ccfe_mode_e;

  // Field order fixes the flag_byte layout, bit four down to bit zero
  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } ccfe_flags_s;

  localparam ccfe_flags_s FLAGS_RST = '{h: 1'b0, i: 1'b1, n: 1'b0, z: 1'b0, c: 1'b0};

  typedef struct packed {
    logic [7:0]  result;
    ccfe_flags_s flags;
    logic        wr_acc;
  } ccfe_alu_s;

endpackage : ccfe_pkg

// ===== core/ccfe_flag_unit.sv
`timescale 1ns/1ps
module ccfe_flag_unit (
  input  wire ccfe_pkg::ccfe_op_e    op,
  input  wire logic [7:0]            acc,
  input  wire logic [7:0]            opnd,
  input  wire logic [2:0]            bit_sel,
  input  wire ccfe_pkg::ccfe_flags_s flags_in,
  output ccfe_pkg::ccfe_alu_s        alu_out
);
  import ccfe_pkg::*;

  logic       use_cin;
  logic [8:0] cin;
  logic [8:0] sum;
  logic [8:0] diff;
  logic [4:0] low_sum;

  assign use_cin = (op == CCFE_OP_ADC) || (op == CCFE_OP_SBC);
  assign cin     = {8'h00, use_cin & flags_in.c};
  assign sum     = {1'b0, acc} + {1'b0, opnd} + cin;
  assign diff    = {1'b0, acc} - {1'b0, opnd} - cin;
  assign low_sum = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]} + cin[4:0];

  always_comb begin
    alu_out        = '{result: acc, flags: flags_in, wr_acc: 1'b1};
    case (op)
      CCFE_OP_ADD, CCFE_OP_ADC: begin
        alu_out.result  = sum[7:0];
        alu_out.flags.h = low_sum[4];
        alu_out.flags.c = sum[8];
      end
      CCFE_OP_SUB, CCFE_OP_SBC: begin
        alu_out.result  = diff[7:0];
        alu_out.flags.c = diff[8];
      end
      CCFE_OP_CMP: begin
        alu_out.result  = diff[7:0];
        alu_out.flags.c = diff[8];
        alu_out.wr_acc  = 1'b0;
      end
      CCFE_OP_AND: alu_out.result = acc & opnd;
      CCFE_OP_ORA: alu_out.result = acc | opnd;
      CCFE_OP_EOR: alu_out.result = acc ^ opnd;
      CCFE_OP_LDA: alu_out.result = opnd;
      CCFE_OP_LSL: begin
        alu_out.result  = {acc[6:0], 1'b0};
        alu_out.flags.c = acc[7];
      end
      CCFE_OP_LSR: begin
        alu_out.result  = {1'b0, acc[7:1]};
        alu_out.flags.c = acc[0];
      end
      CCFE_OP_ASR: begin
        alu_out.result  = {acc[7], acc[7:1]};
        alu_out.flags.c = acc[0];
      end
      CCFE_OP_ROL: begin
        alu_out.result  = {acc[6:0], flags_in.c};
        alu_out.flags.c = acc[7];
      end
      CCFE_OP_ROR: begin
        alu_out.result  = {flags_in.c, acc[7:1]};
        alu_out.flags.c = acc[0];
      end
      CCFE_OP_BTST: begin
        alu_out.flags.c = opnd[bit_sel];
        alu_out.wr_acc  = 1'b0;
      end
      default: alu_out.wr_acc = 1'b0;
    endcase
    // Bit test touches only the carry; undefined codes touch nothing
    if (op != CCFE_OP_BTST && op <= CCFE_OP_ROR) begin
      alu_out.flags.n = alu_out.result[7];
      alu_out.flags.z = (alu_out.result == 8'h00);
    end
  end

endmodule : ccfe_flag_unit

// ===== core/ccfe_top.sv
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ccfe_top (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic [15:0]      mem_addr,
  output logic             mem_rd,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_rvalid,
  input  wire logic        ext_irq_req,
  input  wire logic        timer_irq_req,
  output logic             vector_fetch,
  output logic             vector_src
);
  import ccfe_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT, ST_CALC} ccfe_state_e;

  // Bus slave
  logic        dp_wr;
  logic        dp_rd;
  logic        dp_hit;
  logic [7:0]  dp_addr;
  logic        addr_ok;
  logic        wr_flags;
  logic        wr_acc_reg;
  logic        wr_index;
  logic        wr_pc;
  logic        wr_alu;
  logic        wr_ea;
  logic [31:0] rd_mux;

  // Core state
  ccfe_flags_s flags;
  ccfe_flags_s next_flags;
  logic [7:0]  acc;
  logic [7:0]  offset_reg;
  logic [15:0] pc;
  logic [15:0] next_pc;
  logic [15:0] ea;
  logic [15:0] opnd;
  logic [1:0]  cnt;
  logic [1:0]  len;
  ccfe_mode_e  mode;
  ccfe_state_e state;
  ccfe_alu_s   alu;
  ccfe_mode_e  req_mode;
  logic        mode_ok;
  logic        start;
  logic [1:0]  nbytes;
  logic [15:0] ea_calc;

  // Interrupt state
  logic ext_s1;
  logic ext_s2;
  logic ext_s3;
  logic tmr_s1;
  logic tmr_s2;
  logic tmr_s3;
  logic ext_edge;
  logic tmr_edge;
  logic pend_ext;
  logic pend_tmr;
  logic take;
  logic take_ext;

  assign addr_ok    = hsel & htrans[1] & hready;
  assign wr_flags   = dp_wr & dp_hit & (dp_addr == REG_FLAGS);
  assign wr_acc_reg = dp_wr & dp_hit & (dp_addr == REG_ACC);
  assign wr_index   = dp_wr & dp_hit & (dp_addr == REG_INDEX);
  assign wr_pc      = dp_wr & dp_hit & (dp_addr == REG_PC) & (state == ST_IDLE);
  assign wr_alu     = dp_wr & dp_hit & (dp_addr == REG_ALU_CMD);
  assign wr_ea      = dp_wr & dp_hit & (dp_addr == REG_EA_CMD);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dp_wr   <= 1'b0;
      dp_rd   <= 1'b0;
      dp_hit  <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_wr   <= addr_ok & hwrite;
      dp_rd   <= addr_ok & ~hwrite;
      dp_hit  <= (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'h0);
      dp_addr <= haddr[7:0];
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (dp_hit) begin
      case (dp_addr)
        REG_FLAGS:  rd_mux = {24'h000000, FLAG_PAD, flags};
        REG_ACC:    rd_mux = {24'h000000, acc};
        REG_INDEX:  rd_mux = {24'h000000, offset_reg};
        REG_PC:     rd_mux = {16'h0000, pc};
        REG_EA:     rd_mux = {16'h0000, ea};
        REG_STATUS: begin
          rd_mux[ST_BUSY_BIT]             = (state != ST_IDLE);
          rd_mux[ST_EXT_BIT]              = pend_ext;
          rd_mux[ST_TMR_BIT]              = pend_tmr;
          rd_mux[ST_LEN_LSB +: 2]         = len;
        end
        default:    rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Reads get one wait state so they always see the effect of an earlier write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= ~(addr_ok & ~hwrite);
      hresp     <= 1'b0;
      if (dp_rd) begin
        hrdata <= rd_mux;
      end
    end
  end

  ccfe_flag_unit u_flag_unit (
    .op       (ccfe_op_e'(hwdata[ALU_OP_LSB +: 4])),
    .acc      (acc),
    .opnd     (hwdata[ALU_OPN_LSB +: 8]),
    .bit_sel  (hwdata[ALU_BIT_LSB +: 3]),
    .flags_in (flags),
    .alu_out  (alu)
  );

  // Taking an interrupt raises the mask so the same request is not taken twice
  always_comb begin
    next_flags = flags;
    if (wr_flags) begin
      next_flags = ccfe_flags_s'(hwdata[4:0]);
    end else if (wr_alu) begin
      next_flags = alu.flags;
      next_flags.i = flags.i;
    end
    if (take) begin
      next_flags.i = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags <= FLAGS_RST;
      acc   <= ACC_RST;
    end else begin
      flags <= next_flags;
      if (wr_acc_reg) begin
        acc <= hwdata[7:0];
      end else if (wr_alu && alu.wr_acc) begin
        acc <= alu.result;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      offset_reg <= INDEX_RST;
    end else if (wr_index) begin
      offset_reg <= hwdata[7:0];
    end
  end

  // Interrupt request pins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {ext_s1, ext_s2, ext_s3} <= 3'h0;
      {tmr_s1, tmr_s2, tmr_s3} <= 3'h0;
    end else begin
      {ext_s1, ext_s2, ext_s3} <= {ext_irq_req, ext_s1, ext_s2};
      {tmr_s1, tmr_s2, tmr_s3} <= {timer_irq_req, tmr_s1, tmr_s2};
    end
  end

  assign ext_edge = ext_s2 & ~ext_s3;
  assign tmr_edge = tmr_s2 & ~tmr_s3;
  assign take     = ~flags.i & (pend_ext | pend_tmr);
  assign take_ext = pend_ext;

  // A new edge in the cycle a request is taken keeps it pending
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_ext     <= 1'b0;
      pend_tmr     <= 1'b0;
      vector_fetch <= 1'b0;
      vector_src   <= 1'b0;
    end else begin
      pend_ext     <= ext_edge | (pend_ext & ~(take & take_ext));
      pend_tmr     <= tmr_edge | (pend_tmr & ~(take & ~take_ext));
      vector_fetch <= take;
      if (take) begin
        vector_src <= ~take_ext;
      end
    end
  end

  // Address generator
  assign req_mode = ccfe_mode_e'(hwdata[EA_MODE_LSB +: 3]);
  assign mode_ok  = (req_mode <= CCFE_AM_IX2);
  assign start    = wr_ea & mode_ok & (state == ST_IDLE);
  assign nbytes   = (req_mode == CCFE_AM_DIR || req_mode == CCFE_AM_IX1) ? 2'd1 :
                    (req_mode == CCFE_AM_EXT || req_mode == CCFE_AM_IX2) ? 2'd2 : 2'd0;

  always_comb begin
    case (mode)
      CCFE_AM_IMM: ea_calc = pc;
      CCFE_AM_DIR: ea_calc = {8'h00, opnd[7:0]};
      CCFE_AM_EXT: ea_calc = opnd;
      CCFE_AM_IX0: ea_calc = {8'h00, offset_reg};
      CCFE_AM_IX1: ea_calc = {8'h00, opnd[7:0]} + {8'h00, offset_reg};
      CCFE_AM_IX2: ea_calc = opnd + {8'h00, offset_reg};
      default:     ea_calc = ea;
    endcase
  end

  always_comb begin
    next_pc = pc;
    if (wr_pc) begin
      next_pc = hwdata[15:0];
    end else if (start) begin
      next_pc = pc + 16'h0001;
    end else if (state == ST_WAIT && mem_rvalid) begin
      next_pc = pc + 16'h0001;
    end else if (state == ST_CALC && mode == CCFE_AM_IMM) begin
      next_pc = pc + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc <= PC_RST;
    end else begin
      pc <= next_pc;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state    <= ST_IDLE;
      mode     <= CCFE_AM_IMM;
      cnt      <= 2'd0;
      len      <= 2'd0;
      opnd     <= 16'h0000;
      ea       <= EA_RST;
      mem_addr <= 16'h0000;
      mem_rd   <= 1'b0;
    end else begin
      mem_rd <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start) begin
            mode  <= req_mode;
            cnt   <= nbytes;
            len   <= (req_mode == CCFE_AM_IMM) ? 2'd2 : nbytes + 2'd1;
            opnd  <= 16'h0000;
            state <= (nbytes == 2'd0) ? ST_CALC : ST_REQ;
          end
        end
        ST_REQ: begin
          mem_addr <= pc;
          mem_rd   <= 1'b1;
          state    <= ST_WAIT;
        end
        ST_WAIT: begin
          if (mem_rvalid) begin
            opnd  <= {opnd[7:0], mem_rdata};
            cnt   <= cnt - 2'd1;
            state <= (cnt == 2'd1) ? ST_CALC : ST_REQ;
          end
        end
        ST_CALC: begin
          ea    <= ea_calc;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule : ccfe_top

// ===== testbench/ccfe_checker.sv
`timescale 1ns/1ps
module ccfe_checker (
  input logic        clk,
  input logic        sys_rst,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [31:0] hwdata,
  input logic        hready,
  input logic        hreadyout,
  input logic [31:0] hrdata,
  input logic        hresp,
  input logic [15:0] mem_addr,
  input logic        mem_rd,
  input logic        mem_rvalid,
  input logic        vector_fetch,
  input logic        vector_src
);
  logic       ap_v;
  logic       ap_w;
  logic [7:0] ap_a;
  logic       mask_m;
  wire        tk = hsel & htrans[1] & hready;
  wire        dw = ap_v & ap_w & hready;
  // Immediate and no-offset indexed modes finish without any operand fetch
  wire        ea_go = dw && ap_a == 8'h14 && hwdata[2:0] inside {3'h1, 3'h2, 3'h4, 3'h5};

  // Mask as software sees it; a take sets it again
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ap_v   <= 1'b0;
      ap_w   <= 1'b0;
      ap_a   <= 8'h00;
      mask_m <= 1'b1;
    end else begin
      if (hready) begin
        ap_v <= tk;
        ap_w <= hwrite;
        ap_a <= haddr[7:0];
      end
      if (vector_fetch) mask_m <= 1'b1;
      else if (dw && ap_a == 8'h00) mask_m <= hwdata[3];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_RD_WAIT: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait");
  AST_WR_NOWAIT: assert property (tk && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  AST_HRESP_OKAY: assert property (hresp == 1'b0)
    else $error("response not okay");
  AST_FLAGS_PAD: assert property (
      tk && !hwrite && haddr == 32'h0 |-> ##2 hrdata[31:5] == 27'h7)
    else $error("flag byte padding wrong");
  AST_FIRST_FETCH: assert property (ea_go |-> ##[1:2] mem_rd)
    else $error("operand fetch missing");
  AST_NEXT_BYTE: assert property (
      mem_rvalid ##2 mem_rd |-> mem_addr == $past(mem_addr, 2) + 16'h1)
    else $error("second operand byte address wrong");
  AST_MEMRD_PULSE: assert property (mem_rd |=> !mem_rd)
    else $error("fetch strobe longer than one cycle");
  AST_VEC_PULSE: assert property (vector_fetch |=> !vector_fetch)
    else $error("vector fetch longer than one cycle");
  AST_MASK_BLOCKS: assert property (mask_m && $past(mask_m) |-> !vector_fetch)
    else $error("interrupt taken while masked");
  AST_SRC_HOLD: assert property ($changed(vector_src) |-> vector_fetch)
    else $error("vector source moved without a take");

  COV_READ: cover property (tk && !hwrite ##2 hreadyout);
  COV_TWO_BYTES: cover property (mem_rvalid ##2 mem_rd);
  COV_VECTOR: cover property (vector_fetch && vector_src);
endmodule : ccfe_checker

// ===== testbench/ccfe_mem_model.sv
`timescale 1ns/1ps
module ccfe_mem_model (
  input  logic        clk,
  input  logic        sys_rst,
  input  logic [15:0] mem_addr,
  input  logic        mem_rd,
  input  logic [2:0]  lat,
  output logic [7:0]  mem_rdata,
  output logic        mem_rvalid
);
  int          cnt;
  logic [15:0] a;

  // Data toggles outside the valid cycle so a late sample shows up
  always @(posedge clk) begin
    if (sys_rst) begin
      cnt        <= 0;
      mem_rvalid <= 1'b0;
      mem_rdata  <= 8'h00;
    end else begin
      mem_rvalid <= 1'b0;
      mem_rdata  <= ~mem_rdata;
      if (mem_rd) begin
        a   <= mem_addr;
        cnt <= lat + 1;
      end else if (cnt == 1) begin
        mem_rvalid <= 1'b1;
        mem_rdata  <= a[7:0] ^ a[15:8] ^ 8'h5a;
        cnt        <= 0;
      end else if (cnt > 1) cnt <= cnt - 1;
    end
  end
endmodule : ccfe_mem_model

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import ccfe_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        ext_irq_req = 1'b0;
  logic        timer_irq_req = 1'b0;
  logic [2:0]  lat = 3'h1;
  wire         hreadyout, hresp, mem_rd, mem_rvalid, vector_fetch, vector_src;
  wire  [31:0] hrdata;
  wire  [15:0] mem_addr;
  wire  [7:0]  mem_rdata;
  logic [31:0] seed = 32'h39f97e24;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          nvec = 0;
  int          i;
  logic        vsrc = 1'b0;
  logic [7:0]  ma, mx, b;
  logic [4:0]  mf;
  logic [3:0]  op;
  logic [2:0]  bs;
  logic [15:0] p, e, mea;
  logic [31:0] d;
  logic [1:0]  len [7] = '{2'h2, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3, 2'h0};

  ccfe_top DUT (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .mem_addr, .mem_rd, .mem_rdata,
    .mem_rvalid, .ext_irq_req, .timer_irq_req, .vector_fetch, .vector_src);
  ccfe_mem_model mem (.clk, .sys_rst, .mem_addr, .mem_rd, .lat, .mem_rdata, .mem_rvalid);

  initial forever #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (vector_fetch === 1'b1) begin
      nvec <= nvec + 1;
      vsrc <= vector_src;
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [7:0] mb(input logic [15:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h5a;
  endfunction : mb

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge clk); while (!hreadyout);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (!hreadyout);
    d = hrdata;
  endtask : bus

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic alu();
    logic [8:0] r;
    logic       ci;
    ci = (op == 4'h1 || op == 4'h3) ? mf[0] : 1'b0;
    r  = {mf[0], ma};
    case (op)
      4'h0, 4'h1: begin
        r     = {1'b0, ma} + {1'b0, b} + ci;
        mf[4] = ({1'b0, ma[3:0]} + {1'b0, b[3:0]} + ci) > 5'hf;
      end
      4'h2, 4'h3, 4'h4: r = {1'b0, ma} - {1'b0, b} - ci;
      4'h5: r[7:0] = ma & b;
      4'h6: r[7:0] = ma | b;
      4'h7: r[7:0] = ma ^ b;
      4'h8: r[7:0] = b;
      4'h9: r = {ma, 1'b0};
      4'ha: r = {ma[0], 1'b0, ma[7:1]};
      4'hb: r = {ma[0], ma[7], ma[7:1]};
      4'hc: r = {ma, mf[0]};
      4'hd: r = {ma[0], mf[0], ma[7:1]};
      default: ;
    endcase
    if (op == 4'he) mf[0] = b[bs];
    else if (op != 4'hf) begin
      mf[2:0] = {r[7], r[7:0] == 8'h0, r[8]};
      if (op != 4'h4) ma = r[7:0];
    end
  endtask : alu

  task automatic pulse(input logic ex, input logic tm);
    ext_irq_req   <= ex;
    timer_irq_req <= tm;
    repeat (3) @(posedge clk);
    ext_irq_req   <= 1'b0;
    timer_irq_req <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : pulse

  task automatic take(input int n, input logic s);
    bus(1, REG_FLAGS, 32'h0);
    repeat (10) @(posedge clk);
    chk(nvec, n);
    chk(vsrc, s);
    bus(0, REG_FLAGS, 0);
    chk(d, 32'he8);
  endtask : take

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end

  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    bus(0, REG_FLAGS, 0);
    chk(d, 32'he8);
    bus(1, 8'h20, 32'hffffffff);
    bus(0, 8'h20, 0);
    chk(d, 32'h0);
    $display("test reset done");
    for (i = 0; i < 64; i++) begin
      d  = rnd();
      {bs, b, ma, mf} = d[23:0];
      op = i[3:0];
      bus(1, REG_FLAGS, {27'h0, mf});
      bus(1, REG_ACC, {24'h0, ma});
      bus(1, REG_ALU_CMD, {13'h0, bs, b, 4'h0, op});
      alu();
      bus(0, REG_FLAGS, 0);
      chk(d, {24'h0, 3'h7, mf});
      bus(0, REG_ACC, 0);
      chk(d, {24'h0, ma});
    end
    $display("test alu done");
    for (i = 0; i < 21; i++) begin
      d   = rnd();
      {lat, mx, p} = d[26:0];
      op  = i % 7;
      bus(1, REG_INDEX, {24'h0, mx});
      bus(1, REG_PC, {16'h0, p});
      bus(1, REG_EA_CMD, {28'h0, op});
      d = 32'h1;
      repeat (40) if (d[0]) bus(0, REG_STATUS, 0);
      b = mb(p + 16'h1);
      e = {b, mb(p + 16'h2)};
      case (op)
        4'h0: mea = p + 16'h1;
        4'h1: mea = {8'h0, b};
        4'h2: mea = e;
        4'h3: mea = {8'h0, mx};
        4'h4: mea = {8'h0, b} + {8'h0, mx};
        4'h5: mea = e + {8'h0, mx};
        default: ;
      endcase
      bus(0, REG_EA, 0);
      chk(d, {16'h0, mea});
      bus(0, REG_PC, 0);
      chk(d, {16'h0, p + {14'h0, len[op]}});
    end
    $display("test address done");
    bus(1, REG_FLAGS, 32'h8);
    pulse(1'b1, 1'b0);
    chk(nvec, 0);
    bus(0, REG_STATUS, 0);
    chk(d[2:1], 2'h1);
    take(1, 1'b0);
    pulse(1'b1, 1'b1);
    chk(nvec, 1);
    take(2, 1'b0);
    take(3, 1'b1);
    $display("test interrupt done");
    close_out();
  end
endmodule : tb

bind ccfe_top ccfe_checker chk_i (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hreadyout, .hrdata, .hresp, .mem_addr, .mem_rd, .mem_rvalid, .vector_fetch,
  .vector_src);
